// >>> design/ppb_defines.vh
// offsets, field masks, reset values for the parallel port bank
`ifndef PPB_DEFINES_VH
`define PPB_DEFINES_VH

// register indices; byte address is four times the index
`define PPB_IDX_PORT_A_DATA 14'h0000
`define PPB_IDX_PORT_B_DATA 14'h0001
`define PPB_IDX_PORT_C_DATA 14'h0002
`define PPB_IDX_PORT_D_DATA 14'h0003
`define PPB_IDX_PORT_A_DIR 14'h0004
`define PPB_IDX_PORT_B_DIR 14'h0005
`define PPB_IDX_PORT_C_DIR 14'h0006
`define PPB_IDX_PORT_D_DIR 14'h0007
`define PPB_IDX_PORT_E_DATA 14'h0008
`define PPB_IDX_PORT_E_DIR 14'h000c
`define PPB_IDX_PORT_A_PUE 14'h000d
`define PPB_IDX_PORT_C_PUE 14'h000e
`define PPB_IDX_PORT_D_PUE 14'h000f
`define PPB_IDX_PORT_F_DATA 14'h0440
`define PPB_IDX_PORT_G_DATA 14'h0441
`define PPB_IDX_PORT_F_DIR 14'h0444
`define PPB_IDX_PORT_G_DIR 14'h0445
`define PPB_IDX_PORT_F_PUE 14'h0446

// implemented bits per port
`define PPB_MASK_A 8'hff
`define PPB_MASK_B 8'hff
`define PPB_MASK_C 8'h7f
`define PPB_MASK_D 8'hff
`define PPB_MASK_E 8'h3f
`define PPB_MASK_F 8'hff
`define PPB_MASK_G 8'hff

// ports that carry pullups: a, c, d, f
`define PPB_PU_PORTS 7'h2d

// reset values
`define PPB_RST_DIR 8'h00
`define PPB_RST_PUE 8'h00
`define PPB_RST_SYNC 8'h00

// converter channel ranges and can pin mask
`define PPB_CHAN_B_TOP 5'h07
`define PPB_CHAN_A_TOP 5'h0f
`define PPB_CAN_PINS 8'h03

`endif

// >>> design/ppb_port.v
// one 8-bit port: latch, direction, pullup enable and pin synchroniser
`timescale 1ns/1ps
module ppb_port #(
   parameter [7:0] P_MASK = 8'hff,
   parameter P_HAS_PU = 1'b1
) (
   // clock and reset
   input wire i_clk,
   input wire i_nrst,
   // register writes
   input wire [7:0] i_wr_data,
   input wire i_wr_latch,
   input wire i_wr_dir,
   input wire i_wr_pue,
   // peripheral overrides
   input wire [7:0] i_force_in,
   input wire [7:0] i_analog,
   // pins
   input wire [7:0] i_pin_in,
   output wire [7:0] o_pin_out,
   output wire [7:0] o_pin_oe,
   output wire [7:0] o_pin_pu,
   // register read values
   output wire [7:0] o_data_rd,
   output wire [7:0] o_dir_rd,
   output wire [7:0] o_pue_rd
);
`include "ppb_defines.vh"

   reg [7:0] latch_reg;
   reg [7:0] dir_reg;
   reg [7:0] pue_reg;
   reg [7:0] sync1_reg;
   reg [7:0] sync2_reg;
   wire [7:0] pue_mask;

   assign pue_mask = P_HAS_PU ? P_MASK : 8'h00;

   // data latch keeps its contents through reset
   always @(posedge i_clk) begin
      if (i_wr_latch) begin
         latch_reg <= i_wr_data & P_MASK; // see R6 // see R11 // see R12 // see R14
      end
   end

   always @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         dir_reg <= `PPB_RST_DIR; // see R4 // see R5 // see R7 // see R16
         pue_reg <= `PPB_RST_PUE; // see R8 // see R9 // see R10
      end else begin
         if (i_wr_dir) begin
            dir_reg <= i_wr_data & P_MASK; // see R1 // see R5 // see R7
         end
         if (i_wr_pue) begin
            pue_reg <= i_wr_data & pue_mask; // see R2 // see R9
         end
      end
   end

   always @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         sync1_reg <= `PPB_RST_SYNC;
         sync2_reg <= `PPB_RST_SYNC;
      end else begin
         sync1_reg <= i_pin_in;
         sync2_reg <= sync1_reg;
      end
   end

   assign o_pin_out = latch_reg;
   // output buffer on for direction 1 unless a peripheral owns the pin
   assign o_pin_oe = dir_reg & ~i_force_in & ~i_analog; // see R15 // see R13
   // pullup only on inputs, never on analog pins
   assign o_pin_pu = pue_reg & ~dir_reg & ~i_analog; // see R3 // see R2
   assign o_data_rd = ((dir_reg & latch_reg) | (~dir_reg & sync2_reg)) & P_MASK; // see R14
   assign o_dir_rd = dir_reg;
   assign o_pue_rd = pue_reg;

endmodule // ppb_port

// >>> design/ppb_top.v
// parallel port bank: apb register slave and seven port slices
// Notes on behaviour
// R1: every pin individually input or output
// R2: pullups on ports a, c, d, f inputs
// R3: output direction turns pullup off automatically
// R4: port a direction 8 bits, reset 0
// R5: port c direction bits 6-0, bit7 zero
// R6: port e latch bits 5-0, kept through reset
// R7: port e direction bits 5-0, reset 0
// R8: port a pullup enables 8 bits, reset 0
// R9: port c pullup enables bits 6-0 only
// R10: port d pullup enables 8 bits, reset 0
// R11: port f latch 8 bits, kept through reset
// R12: port g latch 8 bits read/write
// R13: keypad, converter and can take pins over
// R14: read latch for outputs, pin for inputs
// R15: direction 1 enables output buffer
// R16: accesses act on bus edge, reset clears
`timescale 1ns/1ps
module ppb_top (
   // clock and reset
   input wire i_clk,
   input wire i_nrst,
   // apb slave
   input wire i_psel,
   input wire i_penable,
   input wire i_pwrite,
   input wire [15:0] i_paddr,
   input wire [31:0] i_pwdata,
   input wire [3:0] i_pstrb,
   output wire o_pready,
   output wire [31:0] o_prdata,
   output wire o_pslverr,
   // peripheral controls
   input wire [7:0] i_keypad_irq_enable,
   input wire i_converter_enable,
   input wire [4:0] i_converter_channel_select,
   input wire i_can_module_enable,
   // port a pins
   input wire [7:0] i_pa_in,
   output wire [7:0] o_pa_out,
   output wire [7:0] o_pa_oe,
   output wire [7:0] o_pa_pu,
   // port b pins
   input wire [7:0] i_pb_in,
   output wire [7:0] o_pb_out,
   output wire [7:0] o_pb_oe,
   output wire [7:0] o_pb_pu,
   // port c pins
   input wire [7:0] i_pc_in,
   output wire [7:0] o_pc_out,
   output wire [7:0] o_pc_oe,
   output wire [7:0] o_pc_pu,
   // port d pins
   input wire [7:0] i_pd_in,
   output wire [7:0] o_pd_out,
   output wire [7:0] o_pd_oe,
   output wire [7:0] o_pd_pu,
   // port e pins
   input wire [7:0] i_pe_in,
   output wire [7:0] o_pe_out,
   output wire [7:0] o_pe_oe,
   output wire [7:0] o_pe_pu,
   // port f pins
   input wire [7:0] i_pf_in,
   output wire [7:0] o_pf_out,
   output wire [7:0] o_pf_oe,
   output wire [7:0] o_pf_pu,
   // port g pins
   input wire [7:0] i_pg_in,
   output wire [7:0] o_pg_out,
   output wire [7:0] o_pg_oe,
   output wire [7:0] o_pg_pu
);
`include "ppb_defines.vh"

   localparam [55:0] PORT_MASKS = {`PPB_MASK_G, `PPB_MASK_F, `PPB_MASK_E, `PPB_MASK_D,
                                   `PPB_MASK_C, `PPB_MASK_B, `PPB_MASK_A};
   localparam [6:0] PU_PORTS = `PPB_PU_PORTS;

   // bus decode
   wire [13:0] reg_idx;
   wire aligned;
   wire setup_phase;
   wire wr_take;
   reg [6:0] sel_data;
   reg [6:0] sel_dir;
   reg [6:0] sel_pue;
   wire hit;

   // per-port buses, port n in bits 8n+7:8n
   wire [55:0] pin_in_all;
   wire [55:0] pin_out_all;
   wire [55:0] pin_oe_all;
   wire [55:0] pin_pu_all;
   wire [55:0] data_rd_all;
   wire [55:0] dir_rd_all;
   wire [55:0] pue_rd_all;
   wire [55:0] force_in_all;
   wire [55:0] analog_all;

   // overrides
   reg [7:0] analog_a;
   reg [7:0] analog_b;
   wire [7:0] can_pins;

   // read path
   reg [7:0] rd_byte;
   reg [31:0] prdata_reg;
   reg [31:0] prdata_next;
   reg pslverr_reg;
   reg pslverr_next;

   assign reg_idx = i_paddr[15:2];
   assign aligned = (i_paddr[1:0] == 2'h0);
   assign setup_phase = i_psel & ~i_penable;
   // write lands on the access edge
   assign wr_take = i_psel & i_penable & i_pwrite & i_pstrb[0]; // see R16

   // address decode into per-port selects
   always @* begin
      sel_data = 7'h00;
      sel_dir = 7'h00;
      sel_pue = 7'h00;
      if (aligned) begin
         case (reg_idx)
            `PPB_IDX_PORT_A_DATA: sel_data[0] = 1'b1;
            `PPB_IDX_PORT_B_DATA: sel_data[1] = 1'b1;
            `PPB_IDX_PORT_C_DATA: sel_data[2] = 1'b1;
            `PPB_IDX_PORT_D_DATA: sel_data[3] = 1'b1;
            `PPB_IDX_PORT_E_DATA: sel_data[4] = 1'b1;
            `PPB_IDX_PORT_F_DATA: sel_data[5] = 1'b1;
            `PPB_IDX_PORT_G_DATA: sel_data[6] = 1'b1;
            `PPB_IDX_PORT_A_DIR: sel_dir[0] = 1'b1;
            `PPB_IDX_PORT_B_DIR: sel_dir[1] = 1'b1;
            `PPB_IDX_PORT_C_DIR: sel_dir[2] = 1'b1;
            `PPB_IDX_PORT_D_DIR: sel_dir[3] = 1'b1;
            `PPB_IDX_PORT_E_DIR: sel_dir[4] = 1'b1;
            `PPB_IDX_PORT_F_DIR: sel_dir[5] = 1'b1;
            `PPB_IDX_PORT_G_DIR: sel_dir[6] = 1'b1;
            `PPB_IDX_PORT_A_PUE: sel_pue[0] = 1'b1;
            `PPB_IDX_PORT_C_PUE: sel_pue[2] = 1'b1;
            `PPB_IDX_PORT_D_PUE: sel_pue[3] = 1'b1;
            `PPB_IDX_PORT_F_PUE: sel_pue[5] = 1'b1;
            default: begin
               sel_data = 7'h00;
            end
         endcase
      end
   end

   assign hit = |{sel_data, sel_dir, sel_pue};

   // converter channel select steers one pin of port b or a to analog
   always @* begin
      analog_a = 8'h00;
      analog_b = 8'h00;
      if (i_converter_enable) begin
         if (i_converter_channel_select <= `PPB_CHAN_B_TOP) begin
            analog_b[i_converter_channel_select[2:0]] = 1'b1; // see R13
         end else if (i_converter_channel_select <= `PPB_CHAN_A_TOP) begin
            analog_a[i_converter_channel_select[2:0]] = 1'b1; // see R13
         end
      end
   end

   // can module takes port c bits 0 and 1
   assign can_pins = i_can_module_enable ? `PPB_CAN_PINS : 8'h00; // see R13

   assign force_in_all = {8'h00, 8'h00, 8'h00, 8'h00, can_pins, 8'h00,
                          i_keypad_irq_enable}; // see R13
   assign analog_all = {8'h00, 8'h00, 8'h00, 8'h00, 8'h00, analog_b, analog_a};

   assign pin_in_all = {i_pg_in, i_pf_in, i_pe_in, i_pd_in, i_pc_in, i_pb_in, i_pa_in};

   genvar gi;
   generate
      for (gi = 0; gi < 7; gi = gi + 1) begin : g_port
         ppb_port #(
            .P_MASK(PORT_MASKS[8*gi+7:8*gi]),
            .P_HAS_PU(PU_PORTS[gi])
         ) u_port (
            .i_clk(i_clk),
            .i_nrst(i_nrst),
            .i_wr_data(i_pwdata[7:0]),
            .i_wr_latch(wr_take & sel_data[gi]), // see R14
            .i_wr_dir(wr_take & sel_dir[gi]), // see R1
            .i_wr_pue(wr_take & sel_pue[gi]), // see R2
            .i_force_in(force_in_all[8*gi+7:8*gi]),
            .i_analog(analog_all[8*gi+7:8*gi]),
            .i_pin_in(pin_in_all[8*gi+7:8*gi]),
            .o_pin_out(pin_out_all[8*gi+7:8*gi]),
            .o_pin_oe(pin_oe_all[8*gi+7:8*gi]),
            .o_pin_pu(pin_pu_all[8*gi+7:8*gi]),
            .o_data_rd(data_rd_all[8*gi+7:8*gi]),
            .o_dir_rd(dir_rd_all[8*gi+7:8*gi]),
            .o_pue_rd(pue_rd_all[8*gi+7:8*gi])
         );
      end
   endgenerate

   // pins out
   assign o_pa_out = pin_out_all[7:0];
   assign o_pa_oe = pin_oe_all[7:0];
   assign o_pa_pu = pin_pu_all[7:0];
   assign o_pb_out = pin_out_all[15:8];
   assign o_pb_oe = pin_oe_all[15:8];
   assign o_pb_pu = pin_pu_all[15:8];
   assign o_pc_out = pin_out_all[23:16];
   assign o_pc_oe = pin_oe_all[23:16];
   assign o_pc_pu = pin_pu_all[23:16];
   assign o_pd_out = pin_out_all[31:24];
   assign o_pd_oe = pin_oe_all[31:24];
   assign o_pd_pu = pin_pu_all[31:24];
   assign o_pe_out = pin_out_all[39:32];
   assign o_pe_oe = pin_oe_all[39:32];
   assign o_pe_pu = pin_pu_all[39:32];
   assign o_pf_out = pin_out_all[47:40];
   assign o_pf_oe = pin_oe_all[47:40];
   assign o_pf_pu = pin_pu_all[47:40];
   assign o_pg_out = pin_out_all[55:48];
   assign o_pg_oe = pin_oe_all[55:48];
   assign o_pg_pu = pin_pu_all[55:48];

   // read byte select; unimplemented bits already masked to zero
   integer pi;
   always @* begin
      rd_byte = 8'h00;
      for (pi = 0; pi < 7; pi = pi + 1) begin
         if (sel_data[pi]) begin
            rd_byte = rd_byte | data_rd_all[8*pi+:8]; // see R14
         end
         if (sel_dir[pi]) begin
            rd_byte = rd_byte | dir_rd_all[8*pi+:8]; // see R5 // see R7
         end
         if (sel_pue[pi]) begin
            rd_byte = rd_byte | pue_rd_all[8*pi+:8]; // see R9
         end
      end
   end

   // read data and error are captured in the setup cycle
   always @* begin
      prdata_next = prdata_reg;
      pslverr_next = pslverr_reg;
      if (setup_phase) begin
         prdata_next = {24'h000000, rd_byte};
         pslverr_next = ~hit;
         if (i_pwrite) begin
            prdata_next = 32'h00000000;
         end
      end
   end

   always @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         prdata_reg <= 32'h00000000; // see R16
         pslverr_reg <= 1'b0;
      end else begin
         prdata_reg <= prdata_next;
         pslverr_reg <= pslverr_next;
      end
   end

   // no wait states
   assign o_pready = 1'b1;
   assign o_prdata = prdata_reg;
   assign o_pslverr = pslverr_reg & i_psel & i_penable;

endmodule // ppb_top

// >>> bench/ppb_top_chk.sv
// assertions on the port bank top-level ports
`timescale 1ns/1ps
module ppb_top_chk (
   // clock and reset
   input wire i_clk,
   input wire i_nrst,
   // apb
   input wire i_psel,
   input wire i_penable,
   input wire i_pwrite,
   input wire [15:0] i_paddr,
   input wire [31:0] i_pwdata,
   input wire [3:0] i_pstrb,
   input wire o_pready,
   input wire [31:0] o_prdata,
   input wire o_pslverr,
   // overrides
   input wire [7:0] i_keypad_irq_enable,
   input wire i_can_module_enable,
   // pins
   input wire [7:0] o_pa_oe,
   input wire [7:0] o_pa_pu,
   input wire [7:0] o_pb_pu,
   input wire [7:0] o_pc_oe,
   input wire [7:0] o_pc_pu,
   input wire [7:0] o_pe_oe,
   input wire [7:0] o_pe_pu,
   input wire [7:0] o_pf_out,
   input wire [7:0] o_pg_pu
);
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_nrst);
   property p_rdy; o_pready; endproperty
   a_rdy: assert property (p_rdy) else $error("pready low");
   property p_err; o_pslverr |-> i_psel && i_penable; endproperty
   a_err: assert property (p_err) else $error("stray error");
   property p_unm; i_psel && !i_penable && i_paddr == 16'h0040 ##1 i_penable |-> o_pslverr;
   endproperty
   a_unm: assert property (p_unm) else $error("no error on unmapped");
   property p_hi; o_prdata[31:8] == 24'h000000; endproperty
   a_hi: assert property (p_hi) else $error("upper read bits set");
   property p_off; (o_pa_oe & o_pa_pu) == 8'h00 && (o_pc_oe & o_pc_pu) == 8'h00; endproperty
   a_off: assert property (p_off) else $error("pullup on output");
   property p_c7; !o_pc_oe[7] && !o_pc_pu[7] && o_pe_oe[7:6] == 2'b00; endproperty
   a_c7: assert property (p_c7) else $error("unimplemented bit active");
   property p_nopu; o_pb_pu == 8'h00 && o_pe_pu == 8'h00 && o_pg_pu == 8'h00; endproperty
   a_nopu: assert property (p_nopu) else $error("pullup on plain port");
   property p_kbd; (i_keypad_irq_enable & o_pa_oe) == 8'h00; endproperty
   a_kbd: assert property (p_kbd) else $error("keypad pin driven");
   property p_can; i_can_module_enable |-> o_pc_oe[1:0] == 2'b00; endproperty
   a_can: assert property (p_can) else $error("can pin driven");
   property p_wrf;
      i_psel && i_penable && i_pwrite && i_pstrb[0] && i_paddr == 16'h1100 && o_pready
      |=> o_pf_out == $past(i_pwdata[7:0]);
   endproperty
   a_wrf: assert property (p_wrf) else $error("latch not loaded");
endmodule // ppb_top_chk

// >>> bench/test_parallel_io_port_bank.sv
// self-checking bench for the port bank
`timescale 1ns/1ps
module test_parallel_io_port_bank;
   logic clk, nrst, psel, pen, pwr, rdy, slv, er, cen, can;
   logic [15:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [3:0] pstrb;
   logic [7:0] kp;
   logic [4:0] ch;
   logic [7:0] pin[7], out[7], oe[7], pu[7], lat[7], dir[7], pue[7];
   int n_errors, n_compared, p;
   int cyc = 0;
   localparam logic [15:0] DA[7] = '{16'h0, 16'h4, 16'h8, 16'hc, 16'h20, 16'h1100, 16'h1104};
   localparam logic [15:0] DD[7] = '{16'h10, 16'h14, 16'h18, 16'h1c, 16'h30, 16'h1110, 16'h1114};
   // odd entry marks a port without pullup register
   localparam logic [15:0] PA[7] = '{16'h34, 16'hffff, 16'h38, 16'h3c, 16'hffff, 16'h1118, 16'hffff};
   localparam logic [7:0] M[7] = '{8'hff, 8'hff, 8'h7f, 8'hff, 8'h3f, 8'hff, 8'hff};
   ppb_top u_ppb_top (.i_clk(clk), .i_nrst(nrst), .i_psel(psel), .i_penable(pen),
      .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata), .i_pstrb(pstrb), .o_pready(rdy),
      .o_prdata(prdata), .o_pslverr(slv), .i_keypad_irq_enable(kp), .i_converter_enable(cen),
      .i_converter_channel_select(ch), .i_can_module_enable(can),
      .i_pa_in(pin[0]), .o_pa_out(out[0]), .o_pa_oe(oe[0]), .o_pa_pu(pu[0]),
      .i_pb_in(pin[1]), .o_pb_out(out[1]), .o_pb_oe(oe[1]), .o_pb_pu(pu[1]),
      .i_pc_in(pin[2]), .o_pc_out(out[2]), .o_pc_oe(oe[2]), .o_pc_pu(pu[2]),
      .i_pd_in(pin[3]), .o_pd_out(out[3]), .o_pd_oe(oe[3]), .o_pd_pu(pu[3]),
      .i_pe_in(pin[4]), .o_pe_out(out[4]), .o_pe_oe(oe[4]), .o_pe_pu(pu[4]),
      .i_pf_in(pin[5]), .o_pf_out(out[5]), .o_pf_oe(oe[5]), .o_pf_pu(pu[5]),
      .i_pg_in(pin[6]), .o_pg_out(out[6]), .o_pg_oe(oe[6]), .o_pg_pu(pu[6]));
   initial begin
      clk = 0;
      forever #25 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc++;
      if (cyc > 20000) begin
         n_errors++;
         test_done;
      end
   end
   task test_done;
      if (n_errors == 0 && n_compared > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task ck(input logic [31:0] g, input logic [31:0] e);
      n_compared++;
      if (g !== e) begin
         n_errors++;
         $display("[FAIL] %0t got %h expected %h", $time, g, e);
      end
   endtask
   task apb(input logic w, input logic [15:0] a, input logic [31:0] d, input logic [3:0] s);
      psel <= 1; pen <= 0; pwr <= w; paddr <= a; pwdata <= d; pstrb <= s;
      @(posedge clk);
      pen <= 1;
      // request stands until pready is sampled high; only the bench timeout ends the wait
      do begin
         @(posedge clk);
      end while (rdy !== 1'b1);
      // read data and error are taken at the edge that samples pready
      rd = prdata;
      er = slv;
      psel <= 0;
      pen <= 0;
      @(posedge clk);
   endtask
   task wr(input logic [15:0] a, input logic [7:0] d);
      apb(1, a, {24'($urandom), d}, 4'h1);
      for (int q = 0; q < 7; q++) begin
         if (a == DA[q]) lat[q] = d & M[q];
         if (a == DD[q]) dir[q] = d & M[q];
         if (a == PA[q]) pue[q] = d & M[q];
      end
   endtask
   task rc(input logic [15:0] a, input logic [7:0] e);
      apb(0, a, 32'h0, 4'h0);
      ck(rd, 32'(e));
      ck(32'(er), 32'(a == 16'h0040));
   endtask
   function logic [7:0] ana(int p);
      return (cen && p < 2 && ch[4:3] == 2'(1 - p)) ? 8'h01 << ch[2:0] : 8'h00;
   endfunction
   function logic [7:0] frc(int p);
      return p == 0 ? kp : p == 2 ? {6'h00, can, can} : 8'h00;
   endfunction
   function logic [7:0] dx(int p);
      return ((lat[p] & dir[p]) | (pin[p] & ~dir[p])) & M[p];
   endfunction
   initial begin
      nrst = 0; psel = 0; pen = 0; pwr = 0; paddr = 0; pwdata = 0; pstrb = 0;
      kp = 0; cen = 0; ch = 0; can = 0; n_errors = 0; n_compared = 0;
      for (int q = 0; q < 7; q++) begin
         pin[q] = 0; dir[q] = 0; pue[q] = 0;
      end
      void'($urandom(32'h1f67f0a4));
      repeat (2) @(posedge clk);
      nrst <= 1;
      @(posedge clk);
      for (int q = 0; q < 7; q++) begin
         ck(32'(oe[q] | pu[q]), 32'h0);
         rc(DD[q], 8'h00);
         if (!PA[q][0]) rc(PA[q], 8'h00);
         wr(DA[q], 8'($urandom));
      end
      repeat (40) begin
         p = $urandom % 7;
         pin[p] <= 8'($urandom);
         wr(DA[p], 8'($urandom));
         wr(DD[p], 8'($urandom));
         if (!PA[p][0]) wr(PA[p], 8'($urandom));
         repeat (3) @(posedge clk);
         rc(DA[p], dx(p));
         rc(DD[p], dir[p]);
         if (!PA[p][0]) rc(PA[p], pue[p]);
         ck(32'(out[p]), 32'(lat[p]));
         kp <= 8'($urandom); cen <= 1'($urandom); ch <= 5'($urandom); can <= 1'($urandom);
         @(posedge clk);
         ck(32'(oe[p]), 32'(dir[p] & ~frc(p) & ~ana(p)));
         ck(32'(pu[p]), 32'(p == 0 || p == 2 || p == 3 || p == 5 ? pue[p] & ~dir[p] & ~ana(p) : 0));
         kp <= 0; cen <= 0; can <= 0;
      end
      rc(16'h0040, 8'h00);
      apb(1, DA[5], 32'(~lat[5]), 4'h0);
      rc(DA[5], dx(5));
      apb(1, 16'h1101, 32'(~lat[5]), 4'h1);
      ck(32'(er), 32'h1);
      ck(32'(out[5]), 32'(lat[5]));
      nrst <= 0;
      repeat (2) @(posedge clk);
      nrst <= 1;
      @(posedge clk);
      for (int q = 0; q < 7; q++) begin
         ck(32'(out[q]), 32'(lat[q]));
         ck(32'(oe[q] | pu[q]), 32'h0);
      end
      test_done;
   end
endmodule // test_parallel_io_port_bank
bind ppb_top ppb_top_chk u_ppb_top_chk (.*);
